// ===== include/cfc_defs.vh
`ifndef CFC_DEFS_VH
`define CFC_DEFS_VH

// Register byte offsets
`define CFC_REG_CTRL 8'h00
`define CFC_REG_TEMP 8'h04
`define CFC_REG_LOAD 8'h08
`define CFC_REG_THR_OIL 8'h0C
`define CFC_REG_THR_CLT 8'h10
`define CFC_REG_THR_AIR 8'h14
`define CFC_REG_STATUS 8'h18
`define CFC_REG_AC_HOLD 8'h1C

// CTRL fields
`define CFC_CTRL_RUN 0
`define CFC_CTRL_BRAKE_EN 1
`define CFC_CTRL_RET_SRC 2
`define CFC_CTRL_RET_LINK 3
`define CFC_CTRL_PGOV 4
`define CFC_CTRL_OIL_FAIL 5
`define CFC_CTRL_CLT_FAIL 6
`define CFC_CTRL_AIR_FAIL 7

// Reset values
`define CFC_CTRL_RST 8'h00
`define CFC_THR_RST 16'h0000
`define CFC_AC_HOLD_RST_S 16'h00B4

// Timing
`define CFC_CLK_HZ 50000000
`define CFC_TICK_MS 1
`define CFC_TICK_CYC (`CFC_CLK_HZ / 1000 * `CFC_TICK_MS)
`define CFC_MIN_ON_S 30
`define CFC_START_INH_S 5
`define CFC_BRAKE_QUAL_S 5
`define CFC_MS_PER_S 1000
`define CFC_SPEED_LIMIT_MPH 8'h14

`endif

// ===== verilog/cfc_fan_ctrl.v
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cfc_defs.vh"

module cfc_fan_ctrl (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire ac_switch_open,
   input wire override_grounded,
   input wire brake_high,
   input wire retarder_in,
   output reg fan_drive_oe,
   output reg fan_on
);

   // Registers written by software: control, sensor values from the engine controller, thresholds and A/C hold time
   reg [7:0] ctrl;
   reg [7:0] oil_t;
   reg [7:0] clt_t;
   reg [7:0] air_t;
   reg [7:0] torque;
   reg [7:0] speed;
   reg [15:0] thr_oil;
   reg [15:0] thr_clt;
   reg [15:0] thr_air;
   reg [15:0] ac_hold_s;

   // Pin synchronisers
   reg [3:0] pin_s1;
   reg [3:0] pin_s2;
   wire ac_open = pin_s2[0];
   wire ovr_act = ~pin_s2[1];
   wire brk_hi = pin_s2[2];
   wire ret_pin = pin_s2[3];

   always @(posedge aclk) begin
      if (!aresetn) begin
         // Override pin idles high; zero here would fake an override
         pin_s1 <= 4'h2;
         pin_s2 <= 4'h2;
      end else begin
         pin_s1 <= {retarder_in, brake_high, override_grounded, ac_switch_open};
         pin_s2 <= pin_s1;
      end
   end

   // AXI4-Lite write: address and data may come in either order
   reg aw_have;
   reg w_have;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_go = aw_have && w_have && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_have && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
               `CFC_REG_CTRL, `CFC_REG_TEMP, `CFC_REG_LOAD, `CFC_REG_THR_OIL,
               `CFC_REG_THR_CLT, `CFC_REG_THR_AIR, `CFC_REG_AC_HOLD,
               `CFC_REG_STATUS: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= `CFC_CTRL_RST;
         oil_t <= 8'h00;
         clt_t <= 8'h00;
         air_t <= 8'h00;
         torque <= 8'h00;
         speed <= 8'h00;
         thr_oil <= `CFC_THR_RST;
         thr_clt <= `CFC_THR_RST;
         thr_air <= `CFC_THR_RST;
         ac_hold_s <= `CFC_AC_HOLD_RST_S;
      end else if (wr_go) begin
         case (aw_addr)
            `CFC_REG_CTRL: begin
               if (w_strb[0]) ctrl <= w_data[7:0];
            end
            `CFC_REG_TEMP: begin
               if (w_strb[0]) oil_t <= w_data[7:0];
               if (w_strb[1]) clt_t <= w_data[15:8];
               if (w_strb[2]) air_t <= w_data[23:16];
            end
            `CFC_REG_LOAD: begin
               if (w_strb[0]) torque <= w_data[7:0];
               if (w_strb[1]) speed <= w_data[15:8];
            end
            // Threshold words: on level in bits 7:0, off level in 15:8
            `CFC_REG_THR_OIL: begin
               if (w_strb[0]) thr_oil[7:0] <= w_data[7:0];
               if (w_strb[1]) thr_oil[15:8] <= w_data[15:8];
            end
            `CFC_REG_THR_CLT: begin
               if (w_strb[0]) thr_clt[7:0] <= w_data[7:0];
               if (w_strb[1]) thr_clt[15:8] <= w_data[15:8];
            end
            // Air word: on 7:0, off 15:8, torque limit 23:16
            `CFC_REG_THR_AIR: begin
               if (w_strb[0]) thr_air[7:0] <= w_data[7:0];
               if (w_strb[1]) thr_air[15:8] <= w_data[15:8];
            end
            `CFC_REG_AC_HOLD: begin
               if (w_strb[0]) ac_hold_s[7:0] <= w_data[7:0];
               if (w_strb[1]) ac_hold_s[15:8] <= w_data[15:8];
            end
            default: begin
            end
         endcase
      end
   end

   reg [7:0] torque_lim;
   always @(posedge aclk) begin
      if (!aresetn) begin
         torque_lim <= 8'hFF;
      end else if (wr_go && aw_addr == `CFC_REG_THR_AIR && w_strb[2]) begin
         torque_lim <= w_data[23:16];
      end
   end

   // One-millisecond tick
   localparam integer TICK_LAST = `CFC_TICK_CYC - 1;
   reg [15:0] tick_cnt;
   reg tick;
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == TICK_LAST[15:0]);
         if (tick_cnt == TICK_LAST[15:0]) begin
            tick_cnt <= 16'h0000;
         end else begin
            tick_cnt <= tick_cnt + 16'h0001;
         end
      end
   end

   // Hysteresis per temperature
   reg oil_hot;
   reg clt_hot;
   reg air_hot;
   always @(posedge aclk) begin
      if (!aresetn) begin
         oil_hot <= 1'b0;
         clt_hot <= 1'b0;
         air_hot <= 1'b0;
      end else begin
         if (oil_t > thr_oil[7:0]) oil_hot <= 1'b1;
         else if (oil_t <= thr_oil[15:8]) oil_hot <= 1'b0;
         if (clt_t > thr_clt[7:0]) clt_hot <= 1'b1;
         else if (clt_t <= thr_clt[15:8]) clt_hot <= 1'b0;
         if (air_t > thr_air[7:0]) air_hot <= 1'b1;
         else if (air_t <= thr_air[15:8]) air_hot <= 1'b0;
      end
   end

   // Millisecond timers; a full 16-bit hold setting needs 26 bits
   reg [23:0] start_ms;
   reg [23:0] brake_ms;
   reg [25:0] ac_ms;
   reg [23:0] on_ms;
   reg started;
   reg brake_qual;
   reg ac_hold;
   localparam integer START_MS = `CFC_START_INH_S * `CFC_MS_PER_S;
   localparam integer BRAKE_MS = `CFC_BRAKE_QUAL_S * `CFC_MS_PER_S;
   localparam integer ON_MS = `CFC_MIN_ON_S * `CFC_MS_PER_S;
   localparam integer MS_PER_S = `CFC_MS_PER_S;
   wire [23:0] start_lim = START_MS[23:0];
   wire [23:0] brake_lim = BRAKE_MS[23:0];
   wire [23:0] on_lim = ON_MS[23:0];
   wire [25:0] ac_lim = {10'h000, ac_hold_s} * MS_PER_S[25:0];
   wire running = ctrl[`CFC_CTRL_RUN];

   // Start-up inhibit
   always @(posedge aclk) begin
      if (!aresetn || !running) begin
         start_ms <= 24'h000000;
         started <= 1'b0;
      end else if (tick && !started) begin
         start_ms <= start_ms + 24'h000001;
         started <= (start_ms + 24'h000001 >= start_lim);
      end
   end

   // Brake qualification: high level held without a break
   always @(posedge aclk) begin
      if (!aresetn || !brk_hi) begin
         brake_ms <= 24'h000000;
         brake_qual <= 1'b0;
      end else if (tick && !brake_qual) begin
         brake_ms <= brake_ms + 24'h000001;
         brake_qual <= (brake_ms + 24'h000001 >= brake_lim);
      end
   end

   // Air-conditioner hold after the switch grounds, only below the speed limit
   always @(posedge aclk) begin
      if (!aresetn) begin
         ac_ms <= 26'h0000000;
         ac_hold <= 1'b0;
      end else if (ac_open) begin
         ac_ms <= 26'h0000000;
         ac_hold <= 1'b1;
      end else if (speed >= `CFC_SPEED_LIMIT_MPH) begin
         ac_hold <= 1'b0;
      end else if (tick && ac_hold) begin
         ac_ms <= ac_ms + 26'h0000001;
         if (ac_ms + 26'h0000001 >= ac_lim) ac_hold <= 1'b0;
      end
   end

   wire ret_act = ctrl[`CFC_CTRL_RET_SRC] ? ctrl[`CFC_CTRL_RET_LINK] : ret_pin;
   wire sens_fail = ctrl[`CFC_CTRL_OIL_FAIL] | ctrl[`CFC_CTRL_CLT_FAIL]
                    | ctrl[`CFC_CTRL_AIR_FAIL];
   wire demand = oil_hot | clt_hot
                 | (air_hot & (torque > torque_lim))
                 | ac_open | ac_hold
                 | sens_fail
                 | (ctrl[`CFC_CTRL_BRAKE_EN] & brake_qual & air_hot)
                 | (ret_act & clt_hot)
                 | ovr_act
                 | ctrl[`CFC_CTRL_PGOV];

   // Output with minimum on-time
   always @(posedge aclk) begin
      if (!aresetn || !started) begin
         fan_on <= 1'b0;
         fan_drive_oe <= 1'b1;
         on_ms <= 24'h000000;
      end else if (!fan_on) begin
         on_ms <= 24'h000000;
         if (demand) begin
            fan_on <= 1'b1;
            fan_drive_oe <= 1'b0;
         end
      end else begin
         if (tick && on_ms < on_lim) on_ms <= on_ms + 24'h000001;
         if (!demand && on_ms >= on_lim) begin
            fan_on <= 1'b0;
            fan_drive_oe <= 1'b1;
         end
      end
   end

   // AXI4-Lite read
   reg [31:0] rd_mux;
   always @* begin
      case (s_axi_araddr)
         `CFC_REG_CTRL: rd_mux = {24'h000000, ctrl};
         `CFC_REG_TEMP: rd_mux = {8'h00, air_t, clt_t, oil_t};
         `CFC_REG_LOAD: rd_mux = {16'h0000, speed, torque};
         `CFC_REG_THR_OIL: rd_mux = {16'h0000, thr_oil};
         `CFC_REG_THR_CLT: rd_mux = {16'h0000, thr_clt};
         `CFC_REG_THR_AIR: rd_mux = {8'h00, torque_lim, thr_air};
         `CFC_REG_AC_HOLD: rd_mux = {16'h0000, ac_hold_s};
         `CFC_REG_STATUS: rd_mux = {20'h00000, pin_s2, started, brake_qual, ac_hold,
                                    air_hot, clt_hot, oil_hot, demand, fan_on};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= (s_axi_araddr <= `CFC_REG_AC_HOLD && s_axi_araddr[1:0] == 2'b00)
                           ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ===== verif/cfc_fan_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cfc_fan_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fan_drive_oe,
   input wire logic fan_on
);
   logic [15:0] since_rst;
   // Inhibit spans far more cycles than this counter can reach
   always @(posedge aclk) begin
      if (!aresetn) since_rst <= 16'h0000;
      else if (since_rst != 16'hFFFF) since_rst <= since_rst + 16'h0001;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_fan_polarity: assert property (fan_on == !fan_drive_oe)
      else $error("fan_on is not the inverse of the drive");
   chk_start_inhibit: assert property (since_rst != 16'hFFFF |-> fan_drive_oe)
      else $error("fan released during start inhibit");
   chk_min_on: assert property ($rose(fan_on) |-> fan_on [*8])
      else $error("fan dropped right after turning on");
   chk_reset_off: assert property ($rose(aresetn) |-> fan_drive_oe && !fan_on)
      else $error("fan not off out of reset");
   chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_b_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("bad write response code");
   cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b10);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (s_axi_arvalid && s_axi_arready);
endmodule
bind cfc_fan_ctrl cfc_fan_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .fan_drive_oe(fan_drive_oe), .fan_on(fan_on));
`default_nettype wire

// ===== verif/cfc_vehicle_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfc_vehicle_model (
   input wire logic fan_drive_oe,
   input wire logic ac_req,
   input wire logic ovr_req,
   output logic ac_switch_open,
   output logic override_grounded,
   output logic fan_running
);
   // Idle A/C switch sits grounded so it demands the fan only while an A/C hold is still running
   assign ac_switch_open = ac_req;
   assign override_grounded = !ovr_req;
   assign fan_running = !fan_drive_oe;
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfc_defs.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic ac_req = 1'b0, ovr_req = 1'b0;
   logic brake_req = 1'b0, ret_req = 1'b0;
   logic [3:0] wstrb = 4'hF;
   wire awready, wready, bvalid, arready, rvalid, ac_open, ovr_gnd, oe, fan_on, fan_run;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   logic [31:0] rd;
   logic [1:0] rsp;
   int mismatches = 0, samples_checked = 0, i;
   always #10 aclk = ~aclk;
   cfc_fan_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ac_switch_open(ac_open), .override_grounded(ovr_gnd), .brake_high(brake_req),
      .retarder_in(ret_req), .fan_drive_oe(oe), .fan_on(fan_on));
   cfc_vehicle_model partner (.fan_drive_oe(oe), .ac_req(ac_req), .ovr_req(ovr_req),
      .ac_switch_open(ac_open), .override_grounded(ovr_gnd), .fan_running(fan_run));
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 100);
      bready <= 1'b0;
      rsp = bresp;
      if (n >= 100) begin
         mismatches++;
         close_out();
      end
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 100);
      rready <= 1'b0;
      rd = rdata;
      rsp = rresp;
      if (n >= 100) begin
         mismatches++;
         close_out();
      end
   endtask
   // Settle first: pins pass two synchroniser flops before status shows them
   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m);
      repeat (8) @(posedge aclk);
      rd_reg(a);
      `CHK(nm, e, rd & m)
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      chk_rd("ctrl", `CFC_REG_CTRL, 32'h0, 32'hFF);
      chk_rd("ac_hold", `CFC_REG_AC_HOLD, {16'h0, `CFC_AC_HOLD_RST_S}, 32'hFFFF);
      chk_rd("trq_lim", `CFC_REG_THR_AIR, 32'h00FF0000, 32'h00FF0000);
      chk_rd("status", `CFC_REG_STATUS, 32'h0, 32'hFF);
      `CHK("rst_oe", 1'b1, oe)
      `CHK("rst_fan", 1'b0, fan_on)
      $display("reset values done");
      rd_reg(8'h40);
      `CHK("bad_rresp", 2'b10, rsp)
      `CHK("bad_rdata", 32'h0, rd)
      wr(8'h40, 32'h1);
      `CHK("bad_bresp", 2'b10, rsp)
      $display("unmapped done");
      wr(`CFC_REG_THR_OIL, 32'h00005064);
      wr(`CFC_REG_TEMP, 32'h65);
      chk_rd("oil_hi", `CFC_REG_STATUS, 32'h6, 32'h6);
      wr(`CFC_REG_TEMP, 32'h5A);
      chk_rd("oil_mid", `CFC_REG_STATUS, 32'h6, 32'h6);
      wr(`CFC_REG_TEMP, 32'h50);
      chk_rd("oil_off", `CFC_REG_STATUS, 32'h0, 32'h6);
      wr(`CFC_REG_THR_CLT, 32'h00005064);
      wr(`CFC_REG_TEMP, 32'h6500);
      chk_rd("clt_hi", `CFC_REG_STATUS, 32'hA, 32'hA);
      wr(`CFC_REG_THR_AIR, 32'h00802832);
      wr(`CFC_REG_TEMP, 32'h3C0000);
      wr(`CFC_REG_LOAD, 32'h10);
      chk_rd("air_only", `CFC_REG_STATUS, 32'h10, 32'h12);
      wr(`CFC_REG_LOAD, 32'h90);
      chk_rd("air_trq", `CFC_REG_STATUS, 32'h12, 32'h12);
      wstrb <= 4'h2;
      wr(`CFC_REG_TEMP, 32'h00656565);
      wstrb <= 4'hF;
      chk_rd("strobe", `CFC_REG_TEMP, 32'h003C6500, 32'hFFFFFFFF);
      wr(`CFC_REG_LOAD, 32'h0);
      wr(`CFC_REG_TEMP, 32'h0);
      $display("temperature done");
      for (i = 4; i < 8; i++) begin
         wr(`CFC_REG_CTRL, 32'h1 << i);
         chk_rd("ctrl_dem", `CFC_REG_STATUS, 32'h2, 32'h2);
         wr(`CFC_REG_CTRL, 32'h0);
         chk_rd("ctrl_idle", `CFC_REG_STATUS, 32'h0, 32'h2);
      end
      ovr_req <= 1'b1;
      chk_rd("override", `CFC_REG_STATUS, 32'h2, 32'h2);
      ovr_req <= 1'b0;
      ac_req <= 1'b1;
      chk_rd("ac_on", `CFC_REG_STATUS, 32'h2, 32'h2);
      ac_req <= 1'b0;
      chk_rd("ac_hold", `CFC_REG_STATUS, 32'h22, 32'h22);
      wr(`CFC_REG_LOAD, {16'h0, `CFC_SPEED_LIMIT_MPH, 8'h00});
      chk_rd("ac_fast", `CFC_REG_STATUS, 32'h0, 32'h22);
      $display("conditions done");
      brake_req <= 1'b1;
      ret_req <= 1'b1;
      chk_rd("pins", `CFC_REG_STATUS, 32'hE00, 32'hF42);
      brake_req <= 1'b0;
      ret_req <= 1'b0;
      $display("pins done");
      ovr_req <= 1'b1;
      wr(`CFC_REG_CTRL, 32'h1);
      repeat (200) @(posedge aclk);
      `CHK("inhibit_oe", 1'b1, oe)
      `CHK("inhibit_fan", 1'b0, fan_run)
      `CHK("inhibit_on", 1'b0, fan_on)
      chk_rd("not_started", `CFC_REG_STATUS, 32'h2, 32'h83);
      $display("inhibit done");
      close_out();
   end
endmodule
`default_nettype wire
